// [hw/nts_pkg.sv]
// package for the nfc active target sequencer: types, states and timing counts
package nts_pkg;
  localparam int RATE_W = 2;
  localparam int TMR_W = 16;
  localparam int GUARD_NS = 75000;
  localparam int CLK_NS = 5;
  localparam int GUARD_CYC = (GUARD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [RATE_W-1:0] RATE_RST = 2'h0;

  // interrupt flag bundle
  typedef struct packed {
    logic rx_start;
    logic rx_end;
    logic bit_rate_detected;
    logic ext_field_on;
    logic ext_field_off;
    logic collision_avoid_done;
    logic gp_timer;
    logic no_response;
  } nts_irq_t;

  // controller direct commands, one-cycle strobes
  typedef struct packed {
    logic go_normal;
    logic start_mask_rx;
    logic transmit;
  } nts_cmd_t;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_RXWAIT = 8'h02,
    ST_RX     = 8'h04,
    ST_WOFF   = 8'h08,
    ST_CA     = 8'h10,
    ST_TX     = 8'h20,
    ST_HOLD   = 8'h40,
    ST_NORESP = 8'h80
  } nts_state_t;
endpackage : nts_pkg

// [hw/nts_timer.sv]
// one-shot down counter used for the guard, mask, hold and no-response waits
`timescale 1ns/1ps
`default_nettype none
module nts_timer import nts_pkg::*; #(
  parameter int W = TMR_W
) (
  input wire logic clk_in,          // system clock
  input wire logic rst_in,          // sync reset
  input wire logic start_in,        // load and run
  input wire logic stop_in,         // abandon count
  input wire logic [W-1:0] load_in, // cycles to wait
  output logic running_out,         // counting
  output logic expire_out           // one-cycle pulse at end
);
  logic [W-1:0] cnt_q;
  logic run_q;
  logic exp_q;

  // start wins over stop so a restart is never dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (start_in) begin
      cnt_q <= load_in;
      run_q <= 1'b1;
      exp_q <= 1'b0;
    end else if (stop_in) begin
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (run_q) begin
      exp_q <= (cnt_q <= W'(1));
      run_q <= (cnt_q > W'(1));
      cnt_q <= cnt_q - W'(1);
    end else begin
      exp_q <= 1'b0;
    end
  end

  assign running_out = run_q;
  assign expire_out = exp_q;
endmodule : nts_timer
`default_nettype wire

// [hw/nts_rate_detect.sv]
// bit-rate recogniser: counts cycles between the first two rising receiver edges
`timescale 1ns/1ps
`default_nettype none
module nts_rate_detect import nts_pkg::*; #(
  parameter int CW = 10,
  parameter logic [CW-1:0] TH_FAST = 10'h040, // below: 424 kbit/s
  parameter logic [CW-1:0] TH_MID = 10'h080   // below: 212, else 106
) (
  input wire logic clk_in,              // system clock
  input wire logic rst_in,              // sync reset
  input wire logic enable_in,           // run recogniser
  input wire logic rx_bit_in,           // receiver output
  output logic done_out,                // one-cycle pulse, rate known
  output logic [RATE_W-1:0] rate_out    // recognised rate code
);
  logic [CW-1:0] cnt_q;
  logic seen_q;
  logic prev_q;
  logic done_q;
  logic [RATE_W-1:0] rate_q;
  logic edge_w;

  assign edge_w = rx_bit_in & ~prev_q;

  // measure one symbol spacing; saturate so a stuck line still decides slowest rate
  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      cnt_q <= '0;
      seen_q <= 1'b0;
      prev_q <= 1'b0;
      done_q <= 1'b0;
      rate_q <= RATE_RST;
    end else begin
      prev_q <= rx_bit_in;
      done_q <= 1'b0;
      if (edge_w && !seen_q) begin
        seen_q <= 1'b1;
        cnt_q <= '0;
      end else if (seen_q && (edge_w || &cnt_q)) begin
        seen_q <= 1'b0;
        done_q <= 1'b1;
        rate_q <= (cnt_q < TH_FAST) ? 2'h2 : (cnt_q < TH_MID) ? 2'h1 : 2'h0;
      end else if (seen_q) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign done_out = done_q;
  assign rate_out = rate_q;
endmodule : nts_rate_detect
`default_nettype wire

// [hw/nts_sequencer.sv]
// nfc active target sequencer top: rate detection, response loop, irq flags
// Notes on behaviour
// - frame start: irq, enable rate recogniser
// - rate known: irq, load detect display
// - response collision avoidance needs detected rate
// - frame to fifo, end-of-receive irq
// - go-normal copies rate, selects normal mode
// - field off: irq, auto response if enabled
// - first response uses count bits for n
// - no collision: field on, irq after guard
// - field off after reply, gp timer delay
// - after field off run no-response timer
// - field on: irq, mask timer, then receive
// - last reply: gp irq, controller clears control
// - target select enables field detector
// - no control bits: low-power peer threshold
// - first field on irq, controller starts mask
`timescale 1ns/1ps
`default_nettype none
module nts_sequencer import nts_pkg::*; #(
  parameter int GUARD_CYCLES = GUARD_CYC // above 4096, shortenable
) (
  input wire logic clk_in,                     // system clock 200 MHz
  input wire logic rst_in,                     // sync reset, active high
  input wire logic target_mode_select_in,      // target operation on
  input wire logic normal_mode_in,             // controller-written mode bit
  input wire logic [7:0] op_control_in,        // operation control bits
  input wire logic auto_response_collision_avoid_in, // auto response enable
  input wire logic response_ca_count_hi_in,    // n high bit
  input wire logic response_ca_count_lo_in,    // n low bit
  input wire logic [TMR_W-1:0] gp_time_in,     // end-of-message to field-off
  input wire logic [TMR_W-1:0] mask_rx_time_in, // mask-receive wait
  input wire logic [TMR_W-1:0] no_resp_time_in, // no-response wait
  input wire logic [TMR_W-1:0] ca_slot_time_in, // one collision slot
  input wire nts_cmd_t cmd_in,                 // direct command strobes
  input wire logic ext_field_in,               // field detector output
  input wire logic collision_in,               // field seen during avoidance
  input wire logic rx_bit_in,                  // receiver output
  input wire logic rx_frame_end_in,            // decoder frame end
  input wire logic [7:0] rx_byte_in,           // decoded byte
  input wire logic rx_byte_valid_in,           // decoded byte strobe
  input wire logic tx_done_in,                 // transmitter finished message
  input wire logic irq_read_in,                // status read strobe
  output logic field_detector_enable_out,      // detector active
  output logic peer_threshold_out,             // use peer detect threshold
  output logic low_power_out,                  // low-power initial mode
  output logic rate_detect_mode_out,           // in rate-detection mode
  output logic [RATE_W-1:0] rate_display_out,  // detected rate
  output logic [RATE_W-1:0] rate_def_out,      // bit-rate definition
  output logic field_on_out,                   // own field driven
  output logic [7:0] fifo_data_out,            // byte to fifo
  output logic fifo_we_out,                    // fifo write strobe
  output nts_irq_t irq_status_out,             // latched flags
  output logic irq_out                         // any flag pending
);
  nts_state_t st_q, st_d;
  nts_irq_t flags_q, ev_w;
  logic rate_known_q;
  logic [RATE_W-1:0] disp_q, def_q;
  logic normal_q;
  logic first_resp_q;
  logic [1:0] ca_left_q;
  logic field_q, field_prev_q;
  logic [7:0] fdata_q;
  logic fwe_q;
  logic rd_en_w, rd_done_w;
  logic [RATE_W-1:0] rd_rate_w;
  logic fon_w, foff_w;
  logic tmr_start_w, tmr_stop_w, tmr_exp_w, tmr_run_w;
  logic [TMR_W-1:0] tmr_load_w;
  logic rx_prev_q, rx_started_q, rx_rise_w;

  assign fon_w = ext_field_in & ~field_prev_q;
  assign foff_w = ~ext_field_in & field_prev_q;
  // receiver rise marks the start of a frame
  assign rx_rise_w = rx_bit_in & ~rx_prev_q;

  // field detector edge memory
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      field_prev_q <= 1'b0;
    end else begin
      field_prev_q <= ext_field_in;
    end
  end

  // receiver edge memory; resets low, the idle level of the receiver output,
  // so no false frame start follows reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_prev_q <= 1'b0;
      rx_started_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_bit_in;
      rx_started_q <= (st_q == ST_RX) && (rx_started_q || rx_rise_w);
    end
  end

  // detector and low-power outputs follow target select and the control bits; peer threshold drops in ST_CA, detect mode is the inverse of normal_q
  assign field_detector_enable_out = target_mode_select_in;
  assign low_power_out = target_mode_select_in && (op_control_in == 8'h00);
  assign peer_threshold_out = target_mode_select_in && st_q != ST_CA;
  assign rate_detect_mode_out = ~normal_q;

  // recogniser runs only from frame start in rate-detection mode
  assign rd_en_w = (st_q == ST_RX) && !normal_q && !rate_known_q;

  nts_rate_detect u_rate (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(rd_en_w),
    .rx_bit_in(rx_bit_in),
    .done_out(rd_done_w),
    .rate_out(rd_rate_w)
  );

  nts_timer u_tmr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(tmr_start_w),
    .stop_in(tmr_stop_w),
    .load_in(tmr_load_w),
    .running_out(tmr_run_w),
    .expire_out(tmr_exp_w)
  );

  // state transitions
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (target_mode_select_in && fon_w) st_d = ST_RXWAIT;
      end
      ST_RXWAIT: begin
        if (tmr_exp_w) st_d = ST_RX;
      end
      ST_RX: begin
        if (rx_frame_end_in) st_d = ST_WOFF;
      end
      ST_WOFF: begin
        if (foff_w && auto_response_collision_avoid_in && rate_known_q) st_d = ST_CA;
        else if (foff_w) st_d = ST_IDLE;
      end
      ST_CA: begin
        if (collision_in) st_d = ST_IDLE;
        else if (tmr_exp_w && ca_left_q == 2'h0) st_d = ST_TX;
      end
      ST_TX: begin
        if (tx_done_in) st_d = ST_HOLD;
      end
      ST_HOLD: begin
        if (tmr_exp_w) st_d = ST_NORESP;
      end
      ST_NORESP: begin
        if (fon_w) st_d = ST_RXWAIT;
        else if (tmr_exp_w) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (!target_mode_select_in) st_d = ST_IDLE;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // timer sharing: the states never need two waits at once
  always_comb begin
    tmr_start_w = 1'b0;
    tmr_load_w = mask_rx_time_in;
    if (st_q == ST_IDLE && cmd_in.start_mask_rx) begin
      tmr_start_w = 1'b1;
    end else if (st_q == ST_RXWAIT && cmd_in.start_mask_rx) begin
      tmr_start_w = 1'b1;
    end else if (st_q == ST_NORESP && fon_w) begin
      tmr_start_w = 1'b1;
    end else if (st_q == ST_WOFF && st_d == ST_CA) begin
      tmr_start_w = 1'b1;
      tmr_load_w = TMR_W'(GUARD_CYCLES);
    end else if (st_q == ST_CA && tmr_exp_w && ca_left_q != 2'h0) begin
      tmr_start_w = 1'b1;
      tmr_load_w = ca_slot_time_in;
    end else if (st_q == ST_TX && tx_done_in) begin
      tmr_start_w = 1'b1;
      tmr_load_w = gp_time_in;
    end else if (st_q == ST_HOLD && tmr_exp_w) begin
      tmr_start_w = 1'b1;
      tmr_load_w = no_resp_time_in;
    end
  end
  // leaving for idle abandons the running wait, unless a wait starts in that same cycle, since start wins
  assign tmr_stop_w = (st_d == ST_IDLE) && (st_q != ST_IDLE);

  // the start-mask command counts at the field edge and in receive wait;
  // a command in idle with no field edge to follow lets the wait run out unused,
  // so the controller simply repeats it once the field-on flag is seen

  // slot counter: n from the count bits on the first response only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ca_left_q <= 2'h0;
      first_resp_q <= 1'b1;
    end else if (st_q == ST_WOFF && st_d == ST_CA) begin
      ca_left_q <= first_resp_q ? {response_ca_count_hi_in, response_ca_count_lo_in} : 2'h0;
      first_resp_q <= 1'b0;
    end else if (st_q == ST_CA && tmr_exp_w && ca_left_q != 2'h0) begin
      ca_left_q <= ca_left_q - 2'h1;
    end else if (!target_mode_select_in) begin
      first_resp_q <= 1'b1;
    end
  end

  // own field: on after guard, off when the hold time ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      field_q <= 1'b0;
    end else if (st_q == ST_CA && st_d == ST_TX) begin
      field_q <= 1'b1;
    end else if (st_q == ST_HOLD && tmr_exp_w) begin
      field_q <= 1'b0;
    end else if (st_d == ST_IDLE) begin
      field_q <= 1'b0;
    end
  end
  assign field_on_out = field_q;

  // rate registers: display loaded by recogniser, definition by go-normal
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      disp_q <= RATE_RST;
      def_q <= RATE_RST;
      normal_q <= 1'b0;
      rate_known_q <= 1'b0;
    end else begin
      if (rd_done_w) begin
        disp_q <= rd_rate_w;
        rate_known_q <= 1'b1;
      end
      if (cmd_in.go_normal) begin
        def_q <= disp_q;
        normal_q <= 1'b1;
        rate_known_q <= 1'b1;
      end else if (!normal_mode_in && normal_q) begin
        normal_q <= 1'b0; // controller returned to rate detection
        rate_known_q <= 1'b0;
      end
    end
  end
  assign rate_display_out = disp_q;
  assign rate_def_out = def_q;

  // decoded bytes pass to the fifo registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fdata_q <= 8'h00;
      fwe_q <= 1'b0;
    end else begin
      fwe_q <= rx_byte_valid_in && st_q == ST_RX;
      if (rx_byte_valid_in) fdata_q <= rx_byte_in;
    end
  end
  assign fifo_data_out = fdata_q;
  assign fifo_we_out = fwe_q;

  // event collection
  always_comb begin
    ev_w = '0;
    ev_w.rx_start = (st_q == ST_RX) && rx_rise_w && !rx_started_q;
    ev_w.rx_end = (st_q == ST_RX) && rx_frame_end_in;
    ev_w.bit_rate_detected = rd_done_w;
    ev_w.ext_field_on = target_mode_select_in && fon_w && (st_q == ST_IDLE || st_q == ST_NORESP);
    ev_w.ext_field_off = target_mode_select_in && foff_w && st_q == ST_WOFF;
    ev_w.collision_avoid_done = (st_q == ST_CA) && (st_d == ST_TX);
    ev_w.gp_timer = (st_q == ST_HOLD) && tmr_exp_w;
    ev_w.no_response = (st_q == ST_NORESP) && tmr_exp_w && !fon_w;
  end

  // sticky flags: a read clears, but a new event in that cycle survives
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_q <= '0;
    end else if (irq_read_in) begin
      flags_q <= ev_w;
    end else begin
      flags_q <= flags_q | ev_w;
    end
  end
  // flag word and request line both come straight from the flag flops
  assign irq_status_out = flags_q;
  assign irq_out = |flags_q;
endmodule : nts_sequencer
`default_nettype wire

// [tb/nts_sequencer_props.sv]
// assertion checker for the nfc active target sequencer ports
`timescale 1ns/1ps
`default_nettype none
module nts_sequencer_props import nts_pkg::*; #(
  parameter int GUARD_CYCLES = GUARD_CYC
) (
  input wire logic clk_in, // clock
  input wire logic rst_in, // sync reset
  input wire logic target_mode_select_in, // target on
  input wire logic [7:0] op_control_in, // control bits
  input wire logic ext_field_in, // field detector
  input wire logic [7:0] rx_byte_in, // decoded byte
  input wire logic rx_byte_valid_in, // byte strobe
  input wire logic irq_read_in, // status read
  input wire nts_cmd_t cmd_in, // commands
  input wire logic field_detector_enable_out, // detector on
  input wire logic low_power_out, // low power
  input wire logic rate_detect_mode_out, // detect mode
  input wire logic [RATE_W-1:0] rate_display_out, // rate shown
  input wire logic [RATE_W-1:0] rate_def_out, // rate used
  input wire logic field_on_out, // own field
  input wire logic [7:0] fifo_data_out, // fifo byte
  input wire logic fifo_we_out, // fifo strobe
  input wire nts_irq_t irq_status_out, // flags
  input wire logic irq_out // any flag
);
  logic [15:0] quiet_q; // cycles with remote field absent
  logic rate_seen_q; // a rate was recognised since reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // guard count restarts whenever the remote field shows
  always_ff @(posedge clk_in) begin
    if (rst_in || ext_field_in) quiet_q <= 16'h0000;
    else if (quiet_q != 16'hffff) quiet_q <= quiet_q + 16'h0001;
  end
  // sticky, so a status read cannot hide an earlier detection
  always_ff @(posedge clk_in) begin
    if (rst_in) rate_seen_q <= 1'b0;
    else if (irq_status_out.bit_rate_detected) rate_seen_q <= 1'b1;
  end
  sequence s_field_up;
    $rose(field_on_out);
  endsequence
  sequence s_field_down;
    !$past(rst_in) && $fell(field_on_out);
  endsequence
  chk_fd_follows: assert property (field_detector_enable_out == target_mode_select_in)
    else $error("detector enable does not follow target select");
  chk_low_power: assert property (low_power_out == (target_mode_select_in && op_control_in == 8'h00))
    else $error("low power mode wrong");
  chk_guard_time: assert property (s_field_up |-> quiet_q >= GUARD_CYCLES)
    else $error("field on before guard time");
  chk_ca_flag: assert property (s_field_up |-> ##[0:1] irq_status_out.collision_avoid_done)
    else $error("no avoidance done flag at field on");
  chk_rate_first: assert property (s_field_up |-> rate_seen_q)
    else $error("response field without detected rate");
  chk_gp_flag: assert property (s_field_down |-> ##[0:1] irq_status_out.gp_timer)
    else $error("no timer flag at field off");
  chk_flag_hold: assert property (!$past(rst_in) && ($past(irq_status_out) & ~irq_status_out) != '0
    |-> $past(irq_read_in))
    else $error("flag dropped without status read");
  chk_irq_any: assert property (irq_out == (irq_status_out != '0))
    else $error("irq line disagrees with flags");
  chk_fifo_write: assert property (fifo_we_out |-> $past(rx_byte_valid_in) && fifo_data_out == $past(rx_byte_in))
    else $error("fifo write without matching byte");
  chk_go_normal: assert property (cmd_in.go_normal && rate_detect_mode_out
    |=> !rate_detect_mode_out && rate_def_out == $past(rate_display_out))
    else $error("normal mode switch wrong");
endmodule // nts_sequencer_props

bind nts_sequencer nts_sequencer_props #(.GUARD_CYCLES(GUARD_CYCLES)) nts_sequencer_props_i (
  .clk_in(clk_in), .rst_in(rst_in), .target_mode_select_in(target_mode_select_in),
  .op_control_in(op_control_in), .ext_field_in(ext_field_in), .rx_byte_in(rx_byte_in),
  .rx_byte_valid_in(rx_byte_valid_in), .irq_read_in(irq_read_in), .cmd_in(cmd_in),
  .field_detector_enable_out(field_detector_enable_out), .low_power_out(low_power_out),
  .rate_detect_mode_out(rate_detect_mode_out), .rate_display_out(rate_display_out),
  .rate_def_out(rate_def_out), .field_on_out(field_on_out), .fifo_data_out(fifo_data_out),
  .fifo_we_out(fifo_we_out), .irq_status_out(irq_status_out), .irq_out(irq_out));
`default_nettype wire

// [tb/nts_initiator_model.sv]
// behavioural remote initiator: field, receiver bits and decoded bytes
`timescale 1ns/1ps
`default_nettype none
module nts_initiator_model (
  input wire logic clk_in, // system clock
  output logic ext_field_out, // remote field present
  output logic collision_out, // field seen in avoidance
  output logic rx_bit_out, // demodulated bit stream
  output logic [7:0] rx_byte_out, // decoded byte
  output logic rx_byte_valid_out, // byte strobe
  output logic rx_frame_end_out // frame end strobe
);
  // quiet start: no field, receiver idle low
  initial begin
    ext_field_out = 1'b0;
    collision_out = 1'b0;
    rx_bit_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_byte_valid_out = 1'b0;
    rx_frame_end_out = 1'b0;
  end
  // field changes only at the bench's command, called at a falling edge
  task automatic set_field(input logic v);
    ext_field_out = v;
  endtask
  // edges spaced by the bit period set the rate, then two decoded bytes
  task automatic send_frame(input int per, input logic [15:0] bytes);
    repeat (4) begin
      repeat (per) @(negedge clk_in);
      rx_bit_out = ~rx_bit_out;
    end
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_in);
      rx_byte_out = bytes[8*i +: 8];
      rx_byte_valid_out = 1'b1;
      @(negedge clk_in);
      rx_byte_valid_out = 1'b0;
      rx_byte_out = ~rx_byte_out; // stale byte must not be reused
    end
    @(negedge clk_in);
    rx_frame_end_out = 1'b1;
    @(negedge clk_in);
    rx_frame_end_out = 1'b0;
  endtask
endmodule // nts_initiator_model
`default_nettype wire

// [tb/nts_sequencer_tb.sv]
// self-checking bench for the nfc active target sequencer
`timescale 1ns/1ps
`default_nettype none
module nts_sequencer_tb import nts_pkg::*;;
  localparam int G = 20;
  localparam int SLOT = 10;
  localparam int GP = 30;
  localparam int MASK = 10;
  localparam int NRESP = 40;
  logic clk_in, rst_in, tsel, nmode, auto_ca, n_hi, n_lo, tx_done, irq_read;
  logic field, coll, rxb, rxv, rxe, fdet, peer, lowp, rdm, fon, fwe, irq;
  logic [7:0] op, rxd, fdata, prev;
  logic [RATE_W-1:0] rdisp, rdef;
  nts_cmd_t cmd;
  nts_irq_t irqs;
  nts_irq_t fq[$];
  logic [7:0] bq[$];
  int fails = 0;
  int n_compared = 0;
  nts_initiator_model model_i (.clk_in(clk_in), .ext_field_out(field), .collision_out(coll),
    .rx_bit_out(rxb), .rx_byte_out(rxd), .rx_byte_valid_out(rxv), .rx_frame_end_out(rxe));
  nts_sequencer #(.GUARD_CYCLES(G)) nts_sequencer_i (.clk_in(clk_in), .rst_in(rst_in),
    .target_mode_select_in(tsel), .normal_mode_in(nmode), .op_control_in(op),
    .auto_response_collision_avoid_in(auto_ca), .response_ca_count_hi_in(n_hi),
    .response_ca_count_lo_in(n_lo), .gp_time_in(16'(GP)), .mask_rx_time_in(16'(MASK)),
    .no_resp_time_in(16'(NRESP)), .ca_slot_time_in(16'(SLOT)), .cmd_in(cmd), .ext_field_in(field),
    .collision_in(coll), .rx_bit_in(rxb), .rx_frame_end_in(rxe), .rx_byte_in(rxd),
    .rx_byte_valid_in(rxv), .tx_done_in(tx_done), .irq_read_in(irq_read),
    .field_detector_enable_out(fdet), .peer_threshold_out(peer), .low_power_out(lowp),
    .rate_detect_mode_out(rdm), .rate_display_out(rdisp), .rate_def_out(rdef), .field_on_out(fon),
    .fifo_data_out(fdata), .fifo_we_out(fwe), .irq_status_out(irqs), .irq_out(irq));
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flags(input nts_irq_t got, input nts_irq_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic expect_flag(input logic [7:0] m);
    fq.push_back(nts_irq_t'(m));
  endtask
  // bounded wait on the own field, counting falling edges
  task automatic wait_fon(input logic v, output int n);
    n = 0;
    while (fon !== v && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // a run of a few hundred cycles; far beyond that means a hang
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
  // newly raised flags and fifo writes are matched against the oldest note
  always @(posedge clk_in) begin
    if (!rst_in && (irqs & ~prev) != 8'h00) chk_flags(irqs & ~prev, fq.size() ? fq.pop_front() : '0);
    if (!rst_in && fwe === 1'b1) chk_val(fdata, bq.size() ? bq.pop_front() : 8'hxx);
    prev <= irqs;
  end
  initial begin
    int per, n, k;
    logic [7:0] b0, b1;
    logic [1:0] rc;
    rst_in = 1; tsel = 1; nmode = 0; op = 0; auto_ca = 0; n_hi = 0; n_lo = 0;
    cmd = '0; tx_done = 0; irq_read = 0;
    void'($urandom(32'h5833));
    repeat (4) @(negedge clk_in);
    rst_in = 0;
    @(negedge clk_in);
    chk_val(fdet, 1);
    chk_val(lowp, 1);
    chk_val(peer, 1);
    k = $urandom % 3;
    per = 'h10 + 'h20 * k;
    rc = 2'(2 - k);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    expect_flag(8'h10);
    model_i.set_field(1);
    @(negedge clk_in);
    cmd.start_mask_rx = 1;
    @(negedge clk_in);
    cmd = '0;
    op = 8'($urandom) | 8'h01;
    repeat (MASK + 4) @(negedge clk_in);
    chk_val(lowp, 0);
    expect_flag(8'h80);
    expect_flag(8'h20);
    bq.push_back(b0);
    bq.push_back(b1);
    expect_flag(8'h40);
    model_i.send_frame(per, {b1, b0});
    repeat (4) @(negedge clk_in);
    chk_val(rdisp, rc);
    cmd.go_normal = 1;
    nmode = 1;
    @(negedge clk_in);
    cmd = '0;
    repeat (2) @(negedge clk_in);
    chk_val(rdef, rc);
    chk_val(rdm, 0);
    k = $urandom % 4;
    {n_hi, n_lo} = 2'(k);
    auto_ca = 1;
    expect_flag(8'h08);
    expect_flag(8'h04);
    model_i.set_field(0);
    wait_fon(1, n);
    chk_val(n >= G + k * SLOT && n <= G + k * SLOT + 6, 1);
    {n_hi, n_lo} = 2'h0;
    repeat (3) @(negedge clk_in);
    expect_flag(8'h02);
    tx_done = 1;
    @(negedge clk_in);
    tx_done = 0;
    wait_fon(0, n);
    chk_val(n >= GP - 2 && n <= GP + 4, 1);
    expect_flag(8'h01);
    repeat (NRESP + 8) @(negedge clk_in);
    chk_val(16'(fq.size()), 0);
    chk_val(16'(bq.size()), 0);
    irq_read = 1;
    @(negedge clk_in);
    irq_read = 0;
    @(negedge clk_in);
    chk_val(irqs, 0);
    chk_val(irq, 0);
    op = 0;
    nmode = 0;
    auto_ca = 0;
    @(negedge clk_in);
    chk_val(lowp, 1);
    chk_val(rdm, 1);
    give_verdict;
  end
endmodule // nts_sequencer_tb
`default_nettype wire
